// ### pmx_params.svh
/*
  Constants for the port alternate-function override block: register byte
  offsets, field positions, reset values and bus response codes.
  Assumes it is included by bare name from the package only; the design modules use the macros that this include defines.
*/
`ifndef PMX_PARAMS_SVH
`define PMX_PARAMS_SVH

`define PMX_ADDR_W        8
`define PMX_PIN_W         8
`define PMX_OFF_CTRL      8'h00
`define PMX_OFF_PA_LATCH  8'h04
`define PMX_OFF_PA_DIR    8'h08
`define PMX_OFF_PB_LATCH  8'h0c
`define PMX_OFF_PB_DIR    8'h10
`define PMX_OFF_PA_PIN    8'h14
`define PMX_OFF_PB_PIN    8'h18
`define PMX_BIT_EXT_EN    0
`define PMX_BIT_PU_DIS    4
`define PMX_RST_BYTE      8'h00
`define PMX_ALL_ONES      8'hff
`define PMX_RESP_OKAY     2'h0
`define PMX_RESP_SLVERR   2'h2
`define PMX_PB_TIMER_LO   4
`define PMX_PB_SPI_MISO   3
`define PMX_PB_SPI_MOSI   2
`define PMX_PB_SPI_SCK    1
`define PMX_PB_SPI_SS     0

`endif

// ### pmx_pkg.sv
/*
  Types shared by the port alternate-function override block.
  Assumes the constants header is available on the include path.
*/
package pmx_pkg;
`include "pmx_params.svh"
  typedef logic [`PMX_PIN_W-1:0]  pmx_byte_t;
  typedef logic [`PMX_ADDR_W-1:0] pmx_addr_t;
  typedef logic [31:0]            pmx_word_t;
  typedef logic [1:0]             pmx_resp_t;
endpackage

// ### pmx_ovr_if.sv
/*
  Bundle of per-pin override terms and port settings for one 8-bit port.
  Assumes the source drives every signal combinationally and the resolver samples them.
*/
interface pmx_ovr_if;
  import pmx_pkg::*;
  pmx_byte_t pullup_override_en;
  pmx_byte_t pullup_override_val;
  pmx_byte_t direction_override_en;
  pmx_byte_t direction_override_val;
  pmx_byte_t port_value_override_en;
  pmx_byte_t port_value_override_val;
  pmx_byte_t latch;
  pmx_byte_t dir;
  logic      global_pullup_disable;
  modport src (output pullup_override_en, pullup_override_val, direction_override_en, direction_override_val,
               port_value_override_en, port_value_override_val, latch, dir, global_pullup_disable);
  modport dst (input  pullup_override_en, pullup_override_val, direction_override_en, direction_override_val,
               port_value_override_en, port_value_override_val, latch, dir, global_pullup_disable);
endinterface

// ### pmx_pin_resolve.sv
/*
  Resolves the override terms of one 8-bit port into registered pin controls.
  Assumes a single clock aclk and synchronous active-low reset aresetn.
*/
module pmx_pin_resolve
  import pmx_pkg::*;
(
  input  logic      aclk,
  input  logic      aresetn,
  pmx_ovr_if.dst    ovr,
  output pmx_byte_t pin_out,
  output pmx_byte_t pin_oe,
  output pmx_byte_t pin_pullup
);

  wire pmx_byte_t oe_nxt;
  wire pmx_byte_t out_nxt;
  wire pmx_byte_t pull_nxt;

  assign oe_nxt  = (ovr.direction_override_en & ovr.direction_override_val)
                 | (~ovr.direction_override_en & ovr.dir);
  assign out_nxt = (ovr.port_value_override_en & ovr.port_value_override_val)
                 | (~ovr.port_value_override_en & ovr.latch);
  // The global disable sits after the override so no peripheral can re-enable a pull-up.
  assign pull_nxt = {`PMX_PIN_W{~ovr.global_pullup_disable}}
                  & ((ovr.pullup_override_en & ovr.pullup_override_val)
                  | (~ovr.pullup_override_en & ~ovr.dir & ovr.latch));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out    <= `PMX_RST_BYTE;
      pin_oe     <= `PMX_RST_BYTE;
      pin_pullup <= `PMX_RST_BYTE;
    end else begin
      pin_out    <= out_nxt;
      pin_oe     <= oe_nxt;
      pin_pullup <= pull_nxt;
    end
  end

  a_pullup_forced_off: assert property (@(posedge aclk) disable iff (!aresetn)
    ovr.global_pullup_disable |=> pin_pullup == `PMX_RST_BYTE)
    else $error("pull-up left on while global disable set");

endmodule

// ### pmx_port_override.sv
/*
  Port alternate-function override logic with an AXI4-Lite register slave.
  Port A is shared with the external memory address/data bus, port B carries
  timer compare outputs on pins 7..4 and the serial peripheral on pins 3..0.
  Assumes all inputs are synchronous to aclk and reset aresetn is synchronous, active low.
*/
// Behaviour
// - Setting the global pull-up disable turns every port pull-up off whatever the pin bits say.
// - The eight low-port pins form the external bus, pin n carrying address bit n and data bit n.
// - With external memory on, a low-port pull-up is forced off during the address phase or a write.
// - A low-port pin outputs address bit n in the address phase and write data bit n during a write.
// - The address-phase signal used by the low-port terms spans exactly the address presentation.
// - Port B pin 7 can output timer 0 compare A or timer 1 compare C once its direction bit is set.
// - Port B pin 6 carries timer 1 compare B when its direction bit is set to output.
// - Port B pin 5 carries timer 1 compare A when its direction bit is set to output.
// - Port B pin 4 carries timer 2 compare A when its direction bit is set to output.
// - The same compare pins carry the timer waveforms when the timers run in a PWM mode.
// - Port B pins 3 to 0 serve the serial peripheral as MISO, MOSI, SCK and SS.
// - Without an override, a pull-up is on only for an input pin with latch set and no global disable.
// - On port B pins 7 to 4 an enabled compare output overrides the value, with no pull or direction override.
module pmx_port_override
  import pmx_pkg::*;
(
  input  logic      aclk,
  input  logic      aresetn,
  input  pmx_addr_t s_axi_awaddr,
  input  logic      s_axi_awvalid,
  output logic      s_axi_awready,
  input  pmx_word_t s_axi_wdata,
  input  logic [3:0] s_axi_wstrb,
  input  logic      s_axi_wvalid,
  output logic      s_axi_wready,
  output pmx_resp_t s_axi_bresp,
  output logic      s_axi_bvalid,
  input  logic      s_axi_bready,
  input  pmx_addr_t s_axi_araddr,
  input  logic      s_axi_arvalid,
  output logic      s_axi_arready,
  output pmx_word_t s_axi_rdata,
  output pmx_resp_t s_axi_rresp,
  output logic      s_axi_rvalid,
  input  logic      s_axi_rready,
  input  logic      address_phase_active,
  input  logic      ext_mem_write,
  input  pmx_byte_t ext_mem_addr_lo,
  input  pmx_byte_t ext_mem_wdata,
  output pmx_byte_t ext_mem_rdata,
  input  logic      timer0_compare_a_out,
  input  logic      timer0_compare_a_en,
  input  logic      timer1_compare_c_out,
  input  logic      timer1_compare_c_en,
  input  logic      timer1_compare_b_out,
  input  logic      timer1_compare_b_en,
  input  logic      timer1_compare_a_out,
  input  logic      timer1_compare_a_en,
  input  logic      timer2_compare_a_out,
  input  logic      timer2_compare_a_en,
  input  logic      spi_enable,
  input  logic      spi_master,
  input  logic      spi_slave_out,
  input  logic      spi_master_out,
  input  logic      spi_sck_out,
  output logic      spi_master_in,
  output logic      spi_slave_in,
  output logic      spi_sck_in,
  output logic      spi_ss_in,
  input  pmx_byte_t porta_in,
  output pmx_byte_t porta_out,
  output pmx_byte_t porta_oe,
  output pmx_byte_t porta_pullup,
  input  pmx_byte_t portb_in,
  output pmx_byte_t portb_out,
  output pmx_byte_t portb_oe,
  output pmx_byte_t portb_pullup
);

  function automatic logic reg_hit(input pmx_addr_t addr, input pmx_addr_t off);
    reg_hit = (addr == off);
  endfunction

  function automatic logic reg_mapped(input pmx_addr_t addr);
    reg_mapped = reg_hit(addr, `PMX_OFF_CTRL) | reg_hit(addr, `PMX_OFF_PA_LATCH)
               | reg_hit(addr, `PMX_OFF_PA_DIR) | reg_hit(addr, `PMX_OFF_PB_LATCH)
               | reg_hit(addr, `PMX_OFF_PB_DIR) | reg_hit(addr, `PMX_OFF_PA_PIN)
               | reg_hit(addr, `PMX_OFF_PB_PIN);
  endfunction

  pmx_byte_t ctrl_r;
  pmx_byte_t pa_latch_r;
  pmx_byte_t pa_dir_r;
  pmx_byte_t pb_latch_r;
  pmx_byte_t pb_dir_r;
  pmx_addr_t awaddr_r;
  pmx_byte_t wbyte_r;
  logic      wlane_r;
  logic      aw_have_r;
  logic      w_have_r;

  wire logic ext_mem_enable        = ctrl_r[`PMX_BIT_EXT_EN];
  wire logic global_pullup_disable = ctrl_r[`PMX_BIT_PU_DIS];

  // Write channel: address and data are caught independently, in either order.
  wire logic aw_take   = s_axi_awvalid & s_axi_awready;
  wire logic w_take    = s_axi_wvalid & s_axi_wready;
  wire logic do_write  = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire logic aw_have_nxt = (aw_have_r | aw_take) & ~do_write;
  wire logic w_have_nxt  = (w_have_r | w_take) & ~do_write;
  wire logic wr_en     = do_write & wlane_r;
  wire logic bvalid_nxt = do_write | (s_axi_bvalid & ~s_axi_bready);

  // Read channel: one read outstanding, answered the cycle after the address is taken.
  wire logic ar_take    = s_axi_arvalid & s_axi_arready;
  wire logic rvalid_nxt = ar_take | (s_axi_rvalid & ~s_axi_rready);
  wire pmx_byte_t rd_byte =
      reg_hit(s_axi_araddr, `PMX_OFF_CTRL)     ? ctrl_r     :
      reg_hit(s_axi_araddr, `PMX_OFF_PA_LATCH) ? pa_latch_r :
      reg_hit(s_axi_araddr, `PMX_OFF_PA_DIR)   ? pa_dir_r   :
      reg_hit(s_axi_araddr, `PMX_OFF_PB_LATCH) ? pb_latch_r :
      reg_hit(s_axi_araddr, `PMX_OFF_PB_DIR)   ? pb_dir_r   :
      reg_hit(s_axi_araddr, `PMX_OFF_PA_PIN)   ? porta_in   :
      reg_hit(s_axi_araddr, `PMX_OFF_PB_PIN)   ? portb_in   : `PMX_RST_BYTE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      awaddr_r      <= `PMX_RST_BYTE;
      wbyte_r       <= `PMX_RST_BYTE;
      wlane_r       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PMX_RESP_OKAY;
    end else begin
      aw_have_r     <= aw_have_nxt;
      w_have_r      <= w_have_nxt;
      s_axi_awready <= ~aw_have_nxt;
      s_axi_wready  <= ~w_have_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      if (aw_take) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        wbyte_r <= s_axi_wdata[`PMX_PIN_W-1:0];
        wlane_r <= s_axi_wstrb[0];
      end
      if (do_write) begin
        s_axi_bresp <= reg_mapped(awaddr_r) ? `PMX_RESP_OKAY : `PMX_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PMX_RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      if (ar_take) begin
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= reg_mapped(s_axi_araddr) ? `PMX_RESP_OKAY : `PMX_RESP_SLVERR;
      end
    end
  end

  // Only the low byte lane holds register bits; pin status words ignore writes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r     <= `PMX_RST_BYTE;
      pa_latch_r <= `PMX_RST_BYTE;
      pa_dir_r   <= `PMX_RST_BYTE;
      pb_latch_r <= `PMX_RST_BYTE;
      pb_dir_r   <= `PMX_RST_BYTE;
    end else if (wr_en) begin
      if (reg_hit(awaddr_r, `PMX_OFF_CTRL)) begin
        ctrl_r <= wbyte_r & ((`PMX_PIN_W'(1) << `PMX_BIT_EXT_EN) | (`PMX_PIN_W'(1) << `PMX_BIT_PU_DIS));
      end
      if (reg_hit(awaddr_r, `PMX_OFF_PA_LATCH)) begin
        pa_latch_r <= wbyte_r;
      end
      if (reg_hit(awaddr_r, `PMX_OFF_PA_DIR)) begin
        pa_dir_r <= wbyte_r;
      end
      if (reg_hit(awaddr_r, `PMX_OFF_PB_LATCH)) begin
        pb_latch_r <= wbyte_r;
      end
      if (reg_hit(awaddr_r, `PMX_OFF_PB_DIR)) begin
        pb_dir_r <= wbyte_r;
      end
    end
  end

  // Port A: the external bus owns the pins whenever the enable bit is set.
  // The address-phase strobe is taken as given by the memory interface, unaltered.
  wire logic      bus_drive = address_phase_active | ext_mem_write;
  wire pmx_byte_t pa_value  = (ext_mem_addr_lo & {`PMX_PIN_W{address_phase_active}})
                            | (ext_mem_wdata & {`PMX_PIN_W{ext_mem_write}});

  pmx_ovr_if pa_ovr ();
  assign pa_ovr.pullup_override_en      = {`PMX_PIN_W{ext_mem_enable & bus_drive}};
  assign pa_ovr.pullup_override_val     = `PMX_RST_BYTE;
  assign pa_ovr.direction_override_en   = {`PMX_PIN_W{ext_mem_enable}};
  assign pa_ovr.direction_override_val  = {`PMX_PIN_W{bus_drive}};
  assign pa_ovr.port_value_override_en  = {`PMX_PIN_W{ext_mem_enable}};
  assign pa_ovr.port_value_override_val = pa_value;
  assign pa_ovr.latch                   = pa_latch_r;
  assign pa_ovr.dir                     = pa_dir_r;
  assign pa_ovr.global_pullup_disable   = global_pullup_disable;

  // Pin 7 merges both compare outputs when both are on; the latch bit picks OR or AND.
  wire logic pb7_both  = timer0_compare_a_en & timer1_compare_c_en;
  wire logic pb7_value = pb7_both ? (pb_latch_r[7] ? (timer0_compare_a_out | timer1_compare_c_out)
                                                   : (timer0_compare_a_out & timer1_compare_c_out))
                                  : (timer0_compare_a_en ? timer0_compare_a_out : timer1_compare_c_out);
  wire logic pb7_en    = timer0_compare_a_en | timer1_compare_c_en;
  // Compare and PWM waveforms share one path, so the pin follows whichever the timer makes.
  wire logic [3:0] tmr_en  = {pb7_en, timer1_compare_b_en, timer1_compare_a_en, timer2_compare_a_en};
  wire logic [3:0] tmr_val = {pb7_value, timer1_compare_b_out, timer1_compare_a_out,
                              timer2_compare_a_out};
  wire logic spi_mst = spi_enable & spi_master;

  pmx_ovr_if pb_ovr ();
  assign pb_ovr.pullup_override_en      = {4'h0, {4{spi_mst}}};
  assign pb_ovr.pullup_override_val     = {4'h0, pb_latch_r[3:0]};
  assign pb_ovr.direction_override_en   = {4'h0, {4{spi_mst}}};
  assign pb_ovr.direction_override_val  = `PMX_RST_BYTE;
  assign pb_ovr.port_value_override_en  = {tmr_en, {3{spi_mst}}, 1'b0};
  assign pb_ovr.port_value_override_val = {tmr_val, spi_slave_out, spi_master_out, spi_sck_out, 1'b0};
  assign pb_ovr.latch                   = pb_latch_r;
  assign pb_ovr.dir                     = pb_dir_r;
  assign pb_ovr.global_pullup_disable   = global_pullup_disable;

  pmx_pin_resolve u_port_a (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ovr        (pa_ovr),
    .pin_out    (porta_out),
    .pin_oe     (porta_oe),
    .pin_pullup (porta_pullup)
  );

  pmx_pin_resolve u_port_b (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ovr        (pb_ovr),
    .pin_out    (portb_out),
    .pin_oe     (portb_oe),
    .pin_pullup (portb_pullup)
  );

  // Inputs handed to peripherals are registered so every output leaves a flip-flop.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_mem_rdata <= `PMX_RST_BYTE;
      spi_master_in <= 1'b0;
      spi_slave_in  <= 1'b0;
      spi_sck_in    <= 1'b0;
      spi_ss_in     <= 1'b0;
    end else begin
      ext_mem_rdata <= porta_in;
      spi_master_in <= portb_in[`PMX_PB_SPI_MISO];
      spi_slave_in  <= portb_in[`PMX_PB_SPI_MOSI];
      spi_sck_in    <= portb_in[`PMX_PB_SPI_SCK];
      spi_ss_in     <= portb_in[`PMX_PB_SPI_SS];
    end
  end

  a_pullups_all_off: assert property (@(posedge aclk) disable iff (!aresetn)
    global_pullup_disable |=> (porta_pullup == `PMX_RST_BYTE) && (portb_pullup == `PMX_RST_BYTE))
    else $error("a pull-up stayed on under the global disable");

  a_bus_pull_off: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_mem_enable && bus_drive |=> porta_pullup == `PMX_RST_BYTE)
    else $error("low-port pull-up on during bus drive");

  a_bus_owns_dir: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_mem_enable |=> porta_oe == ($past(bus_drive) ? `PMX_ALL_ONES : `PMX_RST_BYTE))
    else $error("low-port direction not owned by the bus");

  a_addr_on_pins: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_mem_enable && address_phase_active && !ext_mem_write |=> porta_out == $past(ext_mem_addr_lo))
    else $error("address byte missing from low port");

  a_wdata_on_pins: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_mem_enable && ext_mem_write && !address_phase_active |=> porta_out == $past(ext_mem_wdata))
    else $error("write data missing from low port");

  a_rdata_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    aresetn |=> ext_mem_rdata == $past(porta_in))
    else $error("read data does not follow the low port");

  a_plain_gpio_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ext_mem_enable |=> porta_oe == $past(pa_dir_r) && porta_out == $past(pa_latch_r))
    else $error("low port not plain I/O with the bus off");

  a_pullup_plain: assert property (@(posedge aclk) disable iff (!aresetn)
    !ext_mem_enable && !global_pullup_disable |=> porta_pullup == $past(~pa_dir_r & pa_latch_r))
    else $error("low-port pull-up not from direction and latch");

  a_cmp_b_pin6: assert property (@(posedge aclk) disable iff (!aresetn)
    pb_dir_r[6] && timer1_compare_b_en |=> portb_oe[6] && portb_out[6] == $past(timer1_compare_b_out))
    else $error("timer 1 compare B not on port B pin 6");

  a_timer_no_dir: assert property (@(posedge aclk) disable iff (!aresetn)
    aresetn |=> portb_oe[7:4] == $past(pb_dir_r[7:4]))
    else $error("port B upper direction overridden");

  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid ##0 (s_axi_bvalid throughout (!s_axi_bready [*1])) or s_axi_bvalid)
    else $error("write response not raised after a write");

endmodule

// ### pmx_far_model.sv
/*
  Pin-side model for both ports: resolves each pad level from the block's
  drivers, the pull-ups and an external driver that the bench controls.
  Assumes one clock aclk; undriven pads with no pull-up show a changing pattern.
*/
module pmx_far_model
  import pmx_pkg::*;
(
  input  logic      aclk,
  input  pmx_byte_t porta_out,
  input  pmx_byte_t porta_oe,
  input  pmx_byte_t porta_pullup,
  input  pmx_byte_t porta_ext,
  input  pmx_byte_t porta_ext_en,
  output pmx_byte_t porta_in,
  input  pmx_byte_t portb_out,
  input  pmx_byte_t portb_oe,
  input  pmx_byte_t portb_pullup,
  input  pmx_byte_t portb_ext,
  input  pmx_byte_t portb_ext_en,
  output pmx_byte_t portb_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // A floating pad must not settle to a lucky constant, so it toggles every cycle.
  pmx_byte_t float_r = 8'h55;

  function automatic pmx_byte_t pad(pmx_byte_t o, oe, pu, x, xe, fl);
    pad = (oe & o) | (~oe & xe & x) | (~oe & ~xe & pu) | (~oe & ~xe & ~pu & fl);
  endfunction

  always_ff @(posedge aclk) begin
    float_r <= ~float_r;
  end

  assign porta_in = pad(porta_out, porta_oe, porta_pullup, porta_ext, porta_ext_en, float_r);
  assign portb_in = pad(portb_out, portb_oe, portb_pullup, portb_ext, portb_ext_en, float_r);
endmodule

// ### port_alt_function_override_bench.sv
/*
  Self-checking bench for the port override block: AXI4-Lite register access,
  plain I/O, external memory bus, timer compare pins and serial pins.
  Assumes the pin model pmx_far_model and the design package are compiled first.
*/
module port_alt_function_override_bench
  import pmx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       aclk = 1'h0, aresetn = 1'h0;
  pmx_addr_t  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  pmx_word_t  s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic       s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic       s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  pmx_resp_t  s_axi_bresp, s_axi_rresp;
  logic       address_phase_active = 1'h0, ext_mem_write = 1'h0;
  pmx_byte_t  ext_mem_addr_lo = 8'h00, ext_mem_wdata = 8'h00, ext_mem_rdata;
  logic [4:0] tmr_out = 5'h00, tmr_en = 5'h00;
  logic       spi_enable = 1'h0, spi_master = 1'h0, spi_slave_out = 1'h0, spi_master_out = 1'h0;
  logic       spi_sck_out = 1'h0, spi_master_in, spi_slave_in, spi_sck_in, spi_ss_in;
  pmx_byte_t  porta_in, porta_out, porta_oe, porta_pullup, portb_in, portb_out, portb_oe, portb_pullup;
  pmx_byte_t  porta_ext = 8'h00, porta_ext_en = 8'h00, portb_ext = 8'h00, portb_ext_en = 8'h00;
  int         n_fail = 0, comparisons = 0;

  pmx_port_override uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .address_phase_active, .ext_mem_write, .ext_mem_addr_lo, .ext_mem_wdata, .ext_mem_rdata,
    .timer0_compare_a_out(tmr_out[4]), .timer0_compare_a_en(tmr_en[4]),
    .timer1_compare_c_out(tmr_out[3]), .timer1_compare_c_en(tmr_en[3]),
    .timer1_compare_b_out(tmr_out[2]), .timer1_compare_b_en(tmr_en[2]),
    .timer1_compare_a_out(tmr_out[1]), .timer1_compare_a_en(tmr_en[1]),
    .timer2_compare_a_out(tmr_out[0]), .timer2_compare_a_en(tmr_en[0]),
    .spi_enable, .spi_master, .spi_slave_out, .spi_master_out, .spi_sck_out, .spi_master_in,
    .spi_slave_in, .spi_sck_in, .spi_ss_in, .porta_in, .porta_out, .porta_oe, .porta_pullup,
    .portb_in, .portb_out, .portb_oe, .portb_pullup);

  pmx_far_model far (.aclk, .porta_out, .porta_oe, .porta_pullup, .porta_ext, .porta_ext_en, .porta_in,
    .portb_out, .portb_oe, .portb_pullup, .portb_ext, .portb_ext_en, .portb_in);

  always #2.5 aclk = ~aclk;

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input pmx_word_t got, input pmx_word_t exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hung(input int i);
    if (i >= 50) begin
      n_fail++;
      $display("timeout at %0t", $time);
      final_report();
    end
  endtask

  task automatic pins(input logic b, input pmx_byte_t o, oe, pu);
    chk(b ? portb_out : porta_out, o);
    chk(b ? portb_oe : porta_oe, oe);
    chk(b ? portb_pullup : porta_pullup, pu);
  endtask

  // Address and data are offered together; each valid drops only at the edge that takes it.
  task automatic axi_wr(input pmx_addr_t a, input pmx_byte_t d, input pmx_resp_t er);
    int   i;
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (i = 0; i < 50 && !(aw_ok && w_ok); i++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1 && !aw_ok) begin
        aw_ok = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wready === 1'h1 && !w_ok) begin
        w_ok = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    hung(i);
    for (i = 0; i < 50 && s_axi_bvalid !== 1'h1; i++) @(posedge aclk);
    hung(i);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
  endtask

  task automatic axi_rd(input pmx_addr_t a, input pmx_word_t exp, input pmx_resp_t er);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    // The address stands for at least one edge, so a ready that is already high is sampled with it.
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'h1) break;
    end
    hung(i);
    s_axi_arvalid <= 1'h0;
    for (i = 0; i < 50 && s_axi_rvalid !== 1'h1; i++) @(posedge aclk);
    hung(i);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
  endtask

  // Pin outputs are registered, so two edges after a register write they must show it.
  task automatic settle();
    repeat (2) @(posedge aclk);
    #1;
  endtask

  task automatic bus(input logic adr_ph, wr, input pmx_byte_t ad, wd);
    @(posedge aclk);
    address_phase_active <= adr_ph;
    ext_mem_write <= wr;
    ext_mem_addr_lo <= ad;
    ext_mem_wdata <= wd;
    #1;
  endtask

  task automatic t_regs();
    pmx_addr_t offs[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    for (int k = 0; k < 5; k++) axi_rd(offs[k], 32'h0, 2'h0);
    for (int k = 1; k < 5; k++) axi_wr(offs[k], 8'h5a + 8'(k), 2'h0);
    for (int k = 1; k < 5; k++) axi_rd(offs[k], 32'h5a + 32'(k), 2'h0);
    axi_wr(8'h00, 8'hff, 2'h0);
    axi_rd(8'h00, 32'h11, 2'h0);
    for (int k = 0; k < 5; k++) axi_wr(offs[k], 8'h00, 2'h0);
    axi_wr(8'h1c, 8'hff, 2'h2);
    axi_rd(8'h1c, 32'h0, 2'h2);
    portb_ext <= 8'h96;
    portb_ext_en <= 8'hff;
    axi_wr(8'h18, 8'h00, 2'h0);
    axi_rd(8'h18, 32'h96, 2'h0);
    portb_ext_en <= 8'h00;
    $display("test regs done");
  endtask

  task automatic t_gpio();
    bus(1'h1, 1'h1, 8'h3c, 8'hc3);
    axi_wr(8'h04, 8'ha5, 2'h0);
    axi_wr(8'h08, 8'h0f, 2'h0);
    axi_wr(8'h0c, 8'h0f, 2'h0);
    axi_wr(8'h10, 8'h03, 2'h0);
    settle();
    pins(1'h0, 8'ha5, 8'h0f, 8'ha0);
    pins(1'h1, 8'h0f, 8'h03, 8'h0c);
    axi_wr(8'h00, 8'h10, 2'h0);
    settle();
    pins(1'h0, 8'ha5, 8'h0f, 8'h00);
    pins(1'h1, 8'h0f, 8'h03, 8'h00);
    axi_wr(8'h00, 8'h00, 2'h0);
    $display("test gpio done");
  endtask

  task automatic t_ext();
    axi_wr(8'h04, 8'hff, 2'h0);
    axi_wr(8'h08, 8'h00, 2'h0);
    axi_wr(8'h00, 8'h01, 2'h0);
    bus(1'h1, 1'h0, 8'h5a, 8'h00);
    bus(1'h0, 1'h1, 8'h5a, 8'hc3);
    pins(1'h0, 8'h5a, 8'hff, 8'h00);
    bus(1'h0, 1'h0, 8'h5a, 8'hc3);
    pins(1'h0, 8'hc3, 8'hff, 8'h00);
    porta_ext <= 8'h96;
    porta_ext_en <= 8'hff;
    settle();
    pins(1'h0, 8'h00, 8'h00, 8'hff);
    chk(ext_mem_rdata, 8'h96);
    @(posedge aclk);
    porta_ext_en <= 8'h00;
    axi_wr(8'h00, 8'h00, 2'h0);
    $display("test ext done");
  endtask

  task automatic t_timer();
    int pin;
    axi_wr(8'h0c, 8'hf0, 2'h0);
    axi_wr(8'h10, 8'hf0, 2'h0);
    for (int k = 0; k < 5; k++) begin
      pin = (k == 4) ? 7 : k + 4;
      @(posedge aclk);
      tmr_en <= 5'h01 << k;
      settle();
      pins(1'h1, 8'hf0 & ~(8'h01 << pin), 8'hf0, 8'h00);
    end
    @(posedge aclk);
    tmr_en <= 5'h18;
    tmr_out <= 5'h10;
    settle();
    chk(portb_out, 8'hf0);
    axi_wr(8'h0c, 8'h70, 2'h0);
    settle();
    chk(portb_out, 8'h70);
    axi_wr(8'h10, 8'h00, 2'h0);
    settle();
    chk(portb_oe, 8'h00);
    @(posedge aclk);
    tmr_en <= 5'h00;
    tmr_out <= 5'h00;
    $display("test timer done");
  endtask

  task automatic t_spi();
    @(posedge aclk);
    spi_enable <= 1'h1;
    spi_master <= 1'h1;
    spi_slave_out <= 1'h1;
    spi_sck_out <= 1'h1;
    portb_ext <= 8'h05;
    portb_ext_en <= 8'h0f;
    axi_wr(8'h10, 8'h0f, 2'h0);
    axi_wr(8'h0c, 8'h0b, 2'h0);
    settle();
    chk(portb_oe[3:0], 4'h0);
    chk(portb_pullup[3:0], 4'hb);
    chk(portb_out[3:1], 3'h5);
    chk({spi_master_in, spi_slave_in, spi_sck_in, spi_ss_in}, 4'h5);
    axi_wr(8'h00, 8'h10, 2'h0);
    settle();
    chk(portb_pullup[3:0], 4'h0);
    $display("test spi done");
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    chk({porta_oe, portb_oe, porta_pullup, portb_pullup}, 32'h0);
    aresetn <= 1'h1;
    t_regs();
    t_gpio();
    t_ext();
    t_timer();
    t_spi();
    final_report();
  end
endmodule
